// ---- common/oscd_pkg.sv ----
// oscd_pkg: command codes, reset values and config carriers for the scroll/address decoder
// assumes one byte stream of host writes already framed into bytes with a data/command flag
package oscd_pkg;

    // command opcodes
    localparam logic [7:0] OP_HSCR_RIGHT  = 8'h26;
    localparam logic [7:0] OP_HSCR_LEFT   = 8'h27;
    localparam logic [7:0] OP_VHSCR_RIGHT = 8'h29;
    localparam logic [7:0] OP_VHSCR_LEFT  = 8'h2A;
    localparam logic [7:0] OP_SCR_OFF     = 8'h2E;
    localparam logic [7:0] OP_SCR_ON      = 8'h2F;
    localparam logic [7:0] OP_VAREA       = 8'hA3;
    localparam logic [7:0] OP_ADDR_MODE   = 8'h20;
    localparam logic [7:0] OP_MUX         = 8'hA8;
    localparam logic [7:0] OP_DOFFSET     = 8'hD3;
    localparam logic [7:0] OP_SEGCFG      = 8'hDA;
    localparam logic [7:0] OP_CLKDIV      = 8'hD5;
    localparam logic [7:0] OP_PRECHG      = 8'hD9;
    localparam logic [7:0] OP_SEG_REMAP0  = 8'hA0;
    localparam logic [7:0] OP_SEG_REMAP1  = 8'hA1;
    localparam logic [7:0] OP_COM_NORM    = 8'hC0;
    localparam logic [7:0] OP_COM_REMAP   = 8'hC8;
    localparam logic [7:0] OP_LOWCOL_MAX  = 8'h0F;
    localparam logic [7:0] OP_HICOL_MIN   = 8'h10;
    localparam logic [7:0] OP_HICOL_MAX   = 8'h17;
    localparam logic [7:0] OP_SLINE_MIN   = 8'h40;
    localparam logic [7:0] OP_SLINE_MAX   = 8'h66;

    // limits and field values
    localparam logic [2:0] PAGE_MAX       = 3'h4;
    localparam logic [5:0] MUX_MIN_N      = 6'h0F;
    localparam logic [5:0] MUX_MAX_N      = 6'h26;
    localparam logic [5:0] ROW_MAX        = 6'h26;
    localparam logic [1:0] MODE_HORIZ     = 2'h0;
    localparam logic [1:0] MODE_VERT      = 2'h1;
    localparam logic [1:0] MODE_PAGE      = 2'h2;
    localparam logic [1:0] MODE_BAD       = 2'h3;
    localparam int         BIT_SEGALT     = 4;
    localparam int         BIT_LRSWAP     = 5;
    localparam logic [6:0] COL_END_RST    = 7'h7F;

    // reset values
    localparam logic [5:0] RST_FIXED_ROWS = 6'h00;
    localparam logic [5:0] RST_SCR_ROWS   = 6'h27;
    localparam logic [5:0] RST_MUX_N      = 6'h26;
    localparam logic [3:0] RST_CLK_DIV    = 4'h1;
    localparam logic [3:0] RST_OSC_FREQ   = 4'hC;
    localparam logic [3:0] RST_PRECHG     = 4'h2;

    // scroll step interval in frames, indexed by 3-bit code
    localparam logic [8:0] FRAMES_C0 = 9'h005;
    localparam logic [8:0] FRAMES_C1 = 9'h040;
    localparam logic [8:0] FRAMES_C2 = 9'h080;
    localparam logic [8:0] FRAMES_C3 = 9'h100;
    localparam logic [8:0] FRAMES_C4 = 9'h003;
    localparam logic [8:0] FRAMES_C5 = 9'h004;
    localparam logic [8:0] FRAMES_C6 = 9'h019;
    localparam logic [8:0] FRAMES_C7 = 9'h002;

    // parameter collection states, gray along the usual path
    typedef enum logic [2:0] {
        OSCD_IDLE = 3'b000,
        OSCD_P1   = 3'b001,
        OSCD_P2   = 3'b011,
        OSCD_P3   = 3'b010,
        OSCD_P4   = 3'b110,
        OSCD_P5   = 3'b111,
        OSCD_P6   = 3'b101
    } oscd_state_t;

    // scroll configuration
    typedef struct packed {
        logic       active;
        logic       vertical;    // combined mode
        logic       leftDir;
        logic [2:0] startPage;
        logic [2:0] endPage;
        logic [8:0] stepFrames;
        logic [5:0] vOffset;
        logic [5:0] fixedRows;
        logic [5:0] scrollRows;
    } oscd_scroll_t;

    // panel and timing configuration
    typedef struct packed {
        logic [1:0] addrMode;
        logic [3:0] colLow;
        logic [2:0] colHigh;
        logic [5:0] startLine;
        logic       segRemap;
        logic [5:0] muxN;
        logic       comReverse;
        logic [5:0] dispOffset;
        logic       segAlternate;
        logic       segLrSwap;
        logic [3:0] clkDivM1;
        logic [3:0] oscFreq;
        logic [3:0] preChg1;
        logic [3:0] preChg2;
    } oscd_panel_t;

endpackage : oscd_pkg

// ---- rtl/oscd_decoder.sv ----
// oscd_decoder: decodes host command/data bytes into scroll, addressing and panel settings
// assumes cmdValid is a one-cycle strobe on clk with cmdByte and isData stable with it
// assumes colEnd comes from the column address logic on the same clock
// assumes the panel timing and ram port logic read the settings straight from the ports
`timescale 1ns/1ps

module oscd_decoder
    import oscd_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         cmdValid,
    input  wire logic         isData,
    input  wire logic [7:0]   cmdByte,
    input  wire logic [6:0]   colEnd,
    output logic              ramWrite,
    output logic [6:0]        ramColumn,
    output logic [7:0]        ramData,
    output oscd_scroll_t      scrollCfg,
    output oscd_panel_t       panelCfg,
    output logic              vScrollStep,
    output logic [5:0]        vScrollPos
);

    // collection state, live and pending settings, ram port and scroll position
    oscd_state_t  state_r, state_nxt;
    logic [7:0]   opcode_r, opcode_nxt;
    oscd_scroll_t scroll_r, scroll_nxt;
    oscd_scroll_t setup_r, setup_nxt;   // pending setup collected from parameters
    oscd_panel_t  panel_r, panel_nxt;
    logic [6:0]   col_r, col_nxt;
    logic         wr_r, wr_nxt;
    logic [7:0]   wdata_r, wdata_nxt;
    logic         step_r, step_nxt;
    logic [5:0]   pos_r, pos_nxt;
    logic [2:0]   tmpStart_r, tmpStart_nxt;
    logic         stepReq;
    logic         pagesOk;
    logic [6:0]   posSum;

    // frame interval lookup
    function automatic logic [8:0] frames_of(input logic [2:0] code);
        unique case (code)
            3'h0: frames_of = FRAMES_C0;
            3'h1: frames_of = FRAMES_C1;
            3'h2: frames_of = FRAMES_C2;
            3'h3: frames_of = FRAMES_C3;
            3'h4: frames_of = FRAMES_C4;
            3'h5: frames_of = FRAMES_C5;
            3'h6: frames_of = FRAMES_C6;
            3'h7: frames_of = FRAMES_C7;
        endcase
    endfunction : frames_of

    // a vertical step is requested by any activate while combined mode is configured
    assign stepReq = cmdValid && !isData && (state_r == OSCD_IDLE) && (cmdByte == OP_SCR_ON)
                     && setup_r.vertical;

    // page pair is taken only when both codes are valid and the end is not below the start
    assign pagesOk = (tmpStart_r <= PAGE_MAX) && (cmdByte[2:0] <= PAGE_MAX)
                     && (cmdByte[2:0] >= tmpStart_r);

    // command and parameter decode
    always_comb
    begin
        state_nxt    = state_r;
        opcode_nxt   = opcode_r;
        scroll_nxt   = scroll_r;
        setup_nxt    = setup_r;
        panel_nxt    = panel_r;
        col_nxt      = col_r;
        wr_nxt       = 1'b0;
        wdata_nxt    = wdata_r;
        tmpStart_nxt = tmpStart_r;
        if (cmdValid && isData)
        begin
            // data byte: pointer moves on, and the write goes out with the new column
            wr_nxt    = 1'b1;
            wdata_nxt = cmdByte;
            if (panel_r.addrMode == MODE_PAGE && col_r >= colEnd)
                col_nxt = {panel_r.colHigh, panel_r.colLow};
            else
                col_nxt = col_r + 7'h01;
        end
        else if (cmdValid && state_r == OSCD_IDLE)
        begin
            // opcode byte: single-byte commands act at once, the rest wait for parameters
            opcode_nxt = cmdByte;
            if (cmdByte <= OP_LOWCOL_MAX)
            begin
                panel_nxt.colLow = cmdByte[3:0];
                if (panel_r.addrMode == MODE_PAGE)
                    col_nxt = {panel_r.colHigh, cmdByte[3:0]};
            end
            else if (cmdByte >= OP_HICOL_MIN && cmdByte <= OP_HICOL_MAX)
            begin
                if (panel_r.addrMode == MODE_PAGE)
                begin
                    panel_nxt.colHigh = cmdByte[2:0];
                    col_nxt = {cmdByte[2:0], panel_r.colLow};
                end
            end
            else if (cmdByte >= OP_SLINE_MIN && cmdByte <= OP_SLINE_MAX)
                panel_nxt.startLine = cmdByte[5:0];
            else if (cmdByte == OP_SEG_REMAP0 || cmdByte == OP_SEG_REMAP1)
                panel_nxt.segRemap = cmdByte[0];
            else if (cmdByte == OP_COM_NORM || cmdByte == OP_COM_REMAP)
                panel_nxt.comReverse = cmdByte[3];
            else if (cmdByte == OP_SCR_OFF)
                scroll_nxt.active = 1'b0;
            else if (cmdByte == OP_SCR_ON)
            begin
                scroll_nxt = setup_r;
                scroll_nxt.active = 1'b1;
            end
            // every multi-byte opcode starts parameter collection
            else if (cmdByte == OP_HSCR_RIGHT || cmdByte == OP_HSCR_LEFT
                     || cmdByte == OP_VHSCR_RIGHT || cmdByte == OP_VHSCR_LEFT
                     || cmdByte == OP_VAREA || cmdByte == OP_ADDR_MODE
                     || cmdByte == OP_MUX || cmdByte == OP_DOFFSET
                     || cmdByte == OP_SEGCFG || cmdByte == OP_CLKDIV
                     || cmdByte == OP_PRECHG)
                state_nxt = OSCD_P1;
        end
        else if (cmdValid)
        begin
            // parameter byte for the opcode held in opcode_r
            state_nxt = OSCD_IDLE;
            unique case (opcode_r)
                OP_HSCR_RIGHT, OP_HSCR_LEFT, OP_VHSCR_RIGHT, OP_VHSCR_LEFT:
                begin
                    unique case (state_r)
                        OSCD_P1: state_nxt = OSCD_P2;           // dummy byte
                        OSCD_P2:
                        begin
                            tmpStart_nxt = cmdByte[2:0];
                            state_nxt = OSCD_P3;
                        end
                        OSCD_P3:
                        begin
                            setup_nxt.stepFrames = frames_of(cmdByte[2:0]);
                            state_nxt = OSCD_P4;
                        end
                        OSCD_P4:
                        begin
                            // keep old pages on invalid codes or reversed range
                            if (pagesOk)
                            begin
                                setup_nxt.startPage = tmpStart_r;
                                setup_nxt.endPage   = cmdByte[2:0];
                            end
                            // bit 0 flips meaning between the plain and combined pairs
                            setup_nxt.leftDir  = opcode_r[0] ^ opcode_r[3];
                            setup_nxt.vertical = opcode_r[3];
                            if (!opcode_r[3])
                                setup_nxt.vOffset = '0;
                            state_nxt = OSCD_P5;
                        end
                        OSCD_P5:
                        begin
                            if (opcode_r[3])
                                setup_nxt.vOffset = cmdByte[5:0];
                            else
                                state_nxt = OSCD_P6;
                        end
                        OSCD_P6: state_nxt = OSCD_IDLE;         // trailing dummy
                        default: state_nxt = OSCD_IDLE;
                    endcase
                end
                OP_VAREA:
                begin
                    if (state_r == OSCD_P1)
                    begin
                        setup_nxt.fixedRows = cmdByte[5:0];
                        state_nxt = OSCD_P2;
                    end
                    else
                        setup_nxt.scrollRows = cmdByte[5:0];
                end
                OP_ADDR_MODE:
                    if (cmdByte[1:0] != MODE_BAD)
                        panel_nxt.addrMode = cmdByte[1:0];
                OP_MUX:
                    if (cmdByte[5:0] >= MUX_MIN_N && cmdByte[5:0] <= MUX_MAX_N)
                        panel_nxt.muxN = cmdByte[5:0];
                OP_DOFFSET:
                    if (cmdByte[5:0] <= ROW_MAX)
                        panel_nxt.dispOffset = cmdByte[5:0];
                OP_SEGCFG:
                begin
                    panel_nxt.segAlternate = cmdByte[BIT_SEGALT];
                    panel_nxt.segLrSwap    = cmdByte[BIT_LRSWAP];
                end
                OP_CLKDIV:
                begin
                    panel_nxt.clkDivM1 = cmdByte[3:0];
                    panel_nxt.oscFreq  = cmdByte[7:4];
                end
                OP_PRECHG:
                begin
                    if (cmdByte[3:0] != 4'h0)
                        panel_nxt.preChg1 = cmdByte[3:0];
                    if (cmdByte[7:4] != 4'h0)
                        panel_nxt.preChg2 = cmdByte[7:4];
                end
                default: state_nxt = OSCD_IDLE;
            endcase
        end
    end

    // vertical scroll position: one offset step per combined activate, less the area row count once if the sum reaches it
    // the sum is a bit wider so a large offset cannot wrap silently inside six bits
    always_comb
    begin
        step_nxt = stepReq;
        pos_nxt  = pos_r;
        posSum   = {1'b0, pos_r} + {1'b0, setup_r.vOffset};
        if (stepReq)
        begin
            // rows pushed past the last row of the area come back in at its first row
            if (posSum >= {1'b0, setup_r.scrollRows})
                pos_nxt = 6'(posSum - {1'b0, setup_r.scrollRows});
            else
                pos_nxt = posSum[5:0];
        end
    end

    // registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        // reset values are the power-on settings of the panel
        if (!rst_n)
        begin
            state_r    <= OSCD_IDLE;
            opcode_r   <= 8'h00;
            scroll_r   <= '{active: 1'b0, vertical: 1'b0, leftDir: 1'b0, startPage: 3'h0,
                            endPage: 3'h0, stepFrames: FRAMES_C0, vOffset: 6'h00,
                            fixedRows: RST_FIXED_ROWS, scrollRows: RST_SCR_ROWS};
            setup_r    <= '{active: 1'b0, vertical: 1'b0, leftDir: 1'b0, startPage: 3'h0,
                            endPage: 3'h0, stepFrames: FRAMES_C0, vOffset: 6'h00,
                            fixedRows: RST_FIXED_ROWS, scrollRows: RST_SCR_ROWS};
            panel_r    <= '{addrMode: MODE_PAGE, colLow: 4'h0, colHigh: 3'h0, startLine: 6'h00,
                            segRemap: 1'b0, muxN: RST_MUX_N, comReverse: 1'b0,
                            dispOffset: 6'h00, segAlternate: 1'b1, segLrSwap: 1'b0,
                            clkDivM1: RST_CLK_DIV, oscFreq: RST_OSC_FREQ,
                            preChg1: RST_PRECHG, preChg2: RST_PRECHG};
            col_r      <= 7'h00;
            wr_r       <= 1'b0;
            wdata_r    <= 8'h00;
            step_r     <= 1'b0;
            pos_r      <= 6'h00;
            tmpStart_r <= 3'h0;
        end
        else
        begin
            state_r    <= state_nxt;
            opcode_r   <= opcode_nxt;
            scroll_r   <= scroll_nxt;
            setup_r    <= setup_nxt;
            panel_r    <= panel_nxt;
            col_r      <= col_nxt;
            wr_r       <= wr_nxt;
            wdata_r    <= wdata_nxt;
            step_r     <= step_nxt;
            pos_r      <= pos_nxt;
            tmpStart_r <= tmpStart_nxt;
        end
    end

    // outputs straight from the registers
    assign ramWrite    = wr_r;
    assign ramColumn   = col_r;
    assign ramData     = wdata_r;
    assign scrollCfg   = scroll_r;
    assign panelCfg    = panel_r;
    assign vScrollStep = step_r;
    assign vScrollPos  = pos_r;

endmodule : oscd_decoder

// ---- tb/oscd_decoder_bench.sv ----
// oscd_decoder_bench: self-checking bench for the scroll/address decoder
// assumes the host model drives the byte port; bench drives reset and column end
`timescale 1ns/1ps

module oscd_decoder_bench
    import oscd_pkg::*;
;
    logic         clk;
    logic         rst_n;
    logic [6:0]   colEnd;
    logic         cmdValid;
    logic         isData;
    logic [7:0]   cmdByte;
    logic         ramWrite;
    logic [6:0]   ramColumn;
    logic [7:0]   ramData;
    logic         vScrollStep;
    logic [5:0]   vScrollPos;
    oscd_scroll_t scrollCfg;
    oscd_scroll_t es;
    oscd_panel_t  panelCfg;
    oscd_panel_t  ep;
    int           err_total;
    int           cmp_count;
    int           cycles;
    logic [8:0]   frames [8] = '{9'h005, 9'h040, 9'h080, 9'h100, 9'h003, 9'h004, 9'h019, 9'h002};

    oscd_decoder oscd_decoder_inst (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .isData(isData), .cmdByte(cmdByte), .colEnd(colEnd), .ramWrite(ramWrite),
        .ramColumn(ramColumn), .ramData(ramData), .scrollCfg(scrollCfg), .panelCfg(panelCfg),
        .vScrollStep(vScrollStep), .vScrollPos(vScrollPos));
    oscd_host_model oscd_host_model_inst (.clk(clk), .cmdValid(cmdValid), .isData(isData),
        .cmdByte(cmdByte));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    // byte helpers
    task cmd(input logic [7:0] b);
        oscd_host_model_inst.put(1'b0, b);
    endtask : cmd
    task settle;
        oscd_host_model_inst.rest();
    endtask : settle
    task scroll(input logic [7:0] op, input logic [2:0] sp, iv, ed, input logic [5:0] off);
        cmd(op);
        cmd(8'h00);
        cmd({5'h00, sp});
        cmd({5'h00, iv});
        cmd({5'h00, ed});
        if (op == OP_HSCR_RIGHT || op == OP_HSCR_LEFT)
        begin
            cmd(8'h00);
            cmd(8'hFF);
        end
        else
            cmd({2'h0, off});
    endtask : scroll

    // comparisons
    task report(input logic bad);
        cmp_count++;
        if (bad)
        begin
            err_total++;
            $display("ERROR %0t mismatch panel %h scroll %h col %h", $time, panelCfg, scrollCfg,
                ramColumn);
        end
    endtask : report
    task chk_panel;
        report(panelCfg !== ep);
    endtask : chk_panel
    task chk_scroll;
        report(scrollCfg !== es);
    endtask : chk_scroll
    task chk_ram(input logic w, input logic [6:0] col, input logic [7:0] d);
        report(ramWrite !== w || ramColumn !== col || ramData !== d);
    endtask : chk_ram
    task chk_step(input logic s);
        report(vScrollStep !== s);
    endtask : chk_step
    task chk_pos(input logic [5:0] p);
        report(vScrollPos !== p);
    endtask : chk_pos

    // verdict
    task tally_and_finish;
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        colEnd = 7'h26;
        err_total = 0;
        cmp_count = 0;
        cycles = 0;
        ep = {MODE_PAGE, 4'h0, 3'h0, 6'h00, 1'b0, 6'h26, 1'b0, 6'h00, 1'b1, 1'b0, 4'h1, 4'hC,
              4'h2, 4'h2};
        es = {3'b000, 3'h0, 3'h0, 9'h005, 6'h00, 6'h00, 6'h27};
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk_panel();
        chk_scroll();
        // panel settings, refused values in between
        cmd(OP_MUX); cmd(8'h0E); cmd(OP_MUX); cmd(8'h0F); cmd(OP_DOFFSET); cmd(8'h26);
        cmd(OP_DOFFSET); cmd(8'h27); cmd(OP_PRECHG); cmd(8'h05); cmd(OP_CLKDIV); cmd(8'hA7);
        cmd(OP_SEGCFG); cmd(8'h02); cmd(OP_SEG_REMAP1); cmd(OP_COM_REMAP); cmd(8'h66);
        settle();
        ep.muxN = 6'h0F; ep.dispOffset = 6'h26; ep.preChg1 = 4'h5; ep.clkDivM1 = 4'h7;
        ep.oscFreq = 4'hA; ep.segAlternate = 1'b0; ep.segRemap = 1'b1; ep.comReverse = 1'b1;
        ep.startLine = 6'h26;
        chk_panel();
        cmd(OP_PRECHG); cmd(8'hF3); cmd(OP_SEGCFG); cmd(8'h32); cmd(OP_MUX); cmd(8'h26);
        cmd(OP_SEG_REMAP0); cmd(OP_COM_NORM); cmd(8'h40); settle();
        ep.preChg1 = 4'h3; ep.preChg2 = 4'hF; ep.segAlternate = 1'b1; ep.segLrSwap = 1'b1;
        ep.muxN = 6'h26; ep.segRemap = 1'b0; ep.comReverse = 1'b0; ep.startLine = 6'h00;
        chk_panel();
        // page mode column start, data writes and wrap at column end
        cmd(8'h05); cmd(8'h12); settle();
        ep.colLow = 4'h5; ep.colHigh = 3'h2;
        chk_panel();
        oscd_host_model_inst.put(1'b1, 8'hAA);
        chk_ram(1'b1, 7'h26, 8'hAA);
        oscd_host_model_inst.put(1'b1, 8'h55);
        chk_ram(1'b1, 7'h25, 8'h55);
        settle();
        chk_ram(1'b0, 7'h25, 8'h55);
        // addressing modes, invalid code and page-only column commands
        cmd(OP_ADDR_MODE); cmd(8'h00); cmd(8'h13); cmd(OP_ADDR_MODE); cmd(8'h03); settle();
        ep.addrMode = MODE_HORIZ;
        chk_panel();
        cmd(OP_ADDR_MODE); cmd(8'h01); settle();
        ep.addrMode = MODE_VERT;
        chk_panel();
        cmd(OP_ADDR_MODE); cmd(8'h02); settle();
        ep.addrMode = MODE_PAGE;
        chk_panel();
        // scroll area then every interval code with the horizontal setup
        cmd(OP_VAREA); cmd(8'h02); cmd(8'h10);
        es.active = 1'b1; es.startPage = 3'h1; es.endPage = 3'h4; es.fixedRows = 6'h02;
        es.scrollRows = 6'h10;
        for (int i = 0; i < 8; i++)
        begin
            scroll(OP_HSCR_RIGHT, 3'h1, i[2:0], 3'h4, 6'h00);
            cmd(OP_SCR_ON); settle();
            es.stepFrames = frames[i];
            chk_scroll();
        end
        // invalid pages and reversed pages leave the pages alone
        scroll(OP_HSCR_LEFT, 3'h5, 3'h7, 3'h4, 6'h00);
        scroll(OP_VHSCR_RIGHT, 3'h3, 3'h7, 3'h1, 6'h05); cmd(OP_SCR_ON); settle();
        es.vertical = 1'b1; es.vOffset = 6'h05;
        chk_scroll();
        chk_pos(6'h05);
        cmd(OP_SCR_OFF); settle();
        es.active = 1'b0;
        chk_scroll();
        oscd_host_model_inst.put(1'b1, 8'h3C); settle();
        // whole area scrolls, so a 38-row offset stays below the scroll row count
        cmd(OP_VAREA);
        cmd(8'h00);
        cmd(8'h27);
        // latest setup wins; combined activate gives one vertical step
        scroll(OP_HSCR_RIGHT, 3'h0, 3'h0, 3'h2, 6'h00);
        scroll(OP_VHSCR_LEFT, 3'h2, 3'h4, 3'h3, 6'h26);
        cmd(OP_SCR_ON);
        chk_step(1'b1);
        settle();
        chk_step(1'b0);
        es = {3'b111, 3'h2, 3'h3, 9'h003, 6'h26, 6'h00, 6'h27};
        chk_scroll();
        chk_pos(6'h04);
        tally_and_finish();
    end
endmodule : oscd_decoder_bench

// ---- tb/oscd_decoder_properties.sv ----
// oscd_decoder_properties: port-level checks of the scroll/address decoder
// assumes bound onto oscd_decoder, one clock, asynchronous active-low reset
`timescale 1ns/1ps

module oscd_decoder_properties
    import oscd_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    input wire logic         cmdValid,
    input wire logic         isData,
    input wire logic [7:0]   cmdByte,
    input wire logic [6:0]   colEnd,
    input wire logic         ramWrite,
    input wire logic [6:0]   ramColumn,
    input wire logic [7:0]   ramData,
    input wire oscd_scroll_t scrollCfg,
    input wire oscd_panel_t  panelCfg,
    input wire logic         vScrollStep,
    input wire logic [5:0]   vScrollPos
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // command strobes seen at the byte port
    wire logic onTaken  = cmdValid && !isData && cmdByte == OP_SCR_ON;
    wire logic offTaken = cmdValid && !isData && cmdByte == OP_SCR_OFF;

    // data byte taken, then written one cycle later
    sequence dataTaken;
        cmdValid && isData;
    endsequence
    sequence writeShown;
        ramWrite && ramData == $past(cmdByte);
    endsequence

    write_pulse_a: assert property (dataTaken |=> writeShown)
        else $error("data byte not written");
    write_quiet_a: assert property (!(cmdValid && isData) |=> !ramWrite)
        else $error("write pulse without data byte");
    col_step_a: assert property (dataTaken and ramColumn < colEnd |=>
        ramColumn == $past(ramColumn) + 7'h01) else $error("column not advanced");
    col_wrap_a: assert property (dataTaken and panelCfg.addrMode == MODE_PAGE
        and ramColumn >= colEnd |=> ramColumn == {$past(panelCfg.colHigh), $past(panelCfg.colLow)})
        else $error("page mode column did not wrap");
    scroll_start_a: assert property ($rose(scrollCfg.active) |-> $past(onTaken))
        else $error("scroll started without activate");
    scroll_stop_a: assert property ($fell(scrollCfg.active) |-> $past(offTaken))
        else $error("scroll stopped without deactivate");
    step_cause_a: assert property (vScrollStep |-> $past(onTaken) && scrollCfg.vertical)
        else $error("vertical step without combined activate");
    step_wrap_a: assert property (vScrollStep |-> vScrollPos < scrollCfg.scrollRows)
        else $error("scroll position outside scroll area");
    fields_legal_a: assert property (panelCfg.addrMode != MODE_BAD && panelCfg.muxN >= MUX_MIN_N
        && panelCfg.muxN <= MUX_MAX_N && panelCfg.dispOffset <= ROW_MAX
        && panelCfg.preChg1 != 4'h0 && panelCfg.preChg2 != 4'h0) else $error("illegal setting held");
    pages_legal_a: assert property (scrollCfg.startPage <= scrollCfg.endPage
        && scrollCfg.endPage <= PAGE_MAX) else $error("illegal scroll pages");
    settings_hold_a: assert property (!cmdValid |=> $stable(panelCfg) && $stable(scrollCfg))
        else $error("settings changed with no byte");
endmodule : oscd_decoder_properties

bind oscd_decoder oscd_decoder_properties oscd_decoder_properties_inst (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .isData(isData), .cmdByte(cmdByte),
    .colEnd(colEnd), .ramWrite(ramWrite), .ramColumn(ramColumn), .ramData(ramData),
    .scrollCfg(scrollCfg), .panelCfg(panelCfg), .vScrollStep(vScrollStep),
    .vScrollPos(vScrollPos));

// ---- tb/oscd_host_model.sv ----
// oscd_host_model: host side that hands command, parameter and data bytes to the decoder
// assumes calls start on a falling edge of clk; every byte lasts one clock cycle
`timescale 1ns/1ps

module oscd_host_model
(
    input  wire logic       clk,
    output logic            cmdValid,
    output logic            isData,
    output logic [7:0]      cmdByte
);
    // idle bus at time zero, no byte offered
    initial
    begin
        cmdValid = 1'b0;
        isData   = 1'b0;
        cmdByte  = 8'h00;
    end

    // one byte strobe; the bench picks legal values except in refusal scenarios
    task put(input logic dataFlag, input logic [7:0] value);
        cmdValid = 1'b1;
        isData   = dataFlag;
        cmdByte  = value;
        @(negedge clk);
    endtask : put

    // release: byte lines turn to the inverse so stale values are never reused
    task rest;
        cmdValid = 1'b0;
        cmdByte  = ~cmdByte;
        @(negedge clk);
    endtask : rest
endmodule : oscd_host_model
